// ---- verilog/contact_sel_pkg.sv ----
package contact_sel_pkg;

   // ***********************************************************
   // Widths
   // ***********************************************************
   localparam int NUM_W = 3;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;

   // ***********************************************************
   // Register byte offsets
   // ***********************************************************
   localparam logic [ADDR_W-1:0] OFS_METHOD = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_ASSIGN = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_ZONE = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_PATTERN = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_GROUP = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_PRESET = 5'h14;
   localparam logic [ADDR_W-1:0] OFS_LOCAL = 5'h18;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h1c;

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int METHOD_PAT_POS = 0;
   localparam int METHOD_GRP_POS = 1;
   localparam int METHOD_PRE_POS = 2;
   localparam int ASSIGN_PAT_POS = 0;
   localparam int ASSIGN_GRP_POS = 3;
   localparam int ASSIGN_PRE_POS = 6;
   localparam int STAT_PAT_LOCK_POS = 9;
   localparam int STAT_GRP_LOCK_POS = 10;
   localparam int STAT_PRE_LOCK_POS = 11;
   localparam int STAT_ACT_GRP_POS = 12;

   // ***********************************************************
   // Reset values and ranges
   // ***********************************************************
   localparam logic [2:0] METHOD_RST = 3'h0;
   localparam logic [8:0] ASSIGN_RST = 9'h1ff;
   localparam logic [2:0] ZONE_RST = 3'h0;
   localparam logic [NUM_W-1:0] NUM_RST = 3'h1;
   localparam logic [2:0] ZONE_LOCAL = 3'h5;
   localparam int PATTERN_MAX = 4;
   localparam int GROUP_MAX = 4;
   localparam int PRESET_MAX = 5;

   typedef enum logic {
      METHOD_BINARY = 1'b0,
      METHOD_PLUS_ONE = 1'b1
   } method_e;

endpackage

// ---- verilog/rst_sync.sv ----
`timescale 1ns/1ps
module rst_sync
(
   input wire logic clk,
   input wire logic rstn,
   output logic rstn_sync
);
   logic meta_ff;
   logic sync_ff;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end
      else
      begin
         meta_ff <= 1'b1;
         sync_ff <= meta_ff;
      end
   end

   assign rstn_sync = sync_ff;
endmodule // rst_sync

// ---- verilog/contact_decode.sv ----
`timescale 1ns/1ps
module contact_decode
#(
   parameter int MAX_NUM = 4
)
(
   input wire logic [contact_sel_pkg::NUM_W-1:0] code,
   input wire contact_sel_pkg::method_e method,
   output logic num_valid,
   output logic [contact_sel_pkg::NUM_W-1:0] num,
   output logic ext_lock
);
   import contact_sel_pkg::*;

   localparam logic [NUM_W:0] MAX_V = (NUM_W+1)'(MAX_NUM);

   // Plus-one coding must still fit the number field
   generate
      if (MAX_NUM < 1 || MAX_NUM > 7)
      begin : g_bad_max
         $error("contact_decode: MAX_NUM out of range");
      end
   endgenerate

   logic [NUM_W:0] plus_one;

   always_comb
   begin
      plus_one = {1'b0, code} + (NUM_W+1)'(1);
      if (method == METHOD_BINARY)
      begin
         num_valid = (code != '0) && ({1'b0, code} <= MAX_V);
         num = code;
      end
      else
      begin
         num_valid = (plus_one <= MAX_V);
         num = plus_one[NUM_W-1:0];
      end
      ext_lock = (method == METHOD_PLUS_ONE) || (code != '0);
   end
endmodule // contact_decode

// ---- verilog/contact_number_selector.sv ----
`timescale 1ns/1ps
module contact_number_selector
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic pattern_sel_bit0,
   input wire logic pattern_sel_bit1,
   input wire logic pattern_sel_bit2,
   input wire logic tune_group_bit0,
   input wire logic tune_group_bit1,
   input wire logic tune_group_bit2,
   input wire logic preset_out_bit0,
   input wire logic preset_out_bit1,
   input wire logic preset_out_bit2,
   input wire logic [contact_sel_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [contact_sel_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [contact_sel_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [contact_sel_pkg::NUM_W-1:0] pattern_num,
   output logic [contact_sel_pkg::NUM_W-1:0] tuning_group,
   output logic [contact_sel_pkg::NUM_W-1:0] preset_num
);
   import contact_sel_pkg::*;

   // ***********************************************************
   // Reset and declarations
   // ***********************************************************
   logic rst_n_sync;
   logic [2:0] method_ff;
   logic [8:0] assign_ff;
   logic [2:0] zone_source_setting_ff;
   logic [NUM_W-1:0] pattern_num_ff;
   logic [NUM_W-1:0] group_num_ff;
   logic [NUM_W-1:0] local_tune_group_num_ff;
   logic [NUM_W-1:0] preset_num_ff;
   logic [NUM_W-1:0] active_group_ff;
   logic waitreq_ff;
   logic [DATA_W-1:0] readdata_ff;
   logic [NUM_W-1:0] nxt_pattern_num;
   logic [NUM_W-1:0] nxt_group_num;
   logic [NUM_W-1:0] nxt_local_group;
   logic [NUM_W-1:0] nxt_preset_num;
   logic [DATA_W-1:0] nxt_readdata;
   logic [NUM_W-1:0] pat_code;
   logic [NUM_W-1:0] grp_code;
   logic [NUM_W-1:0] pre_code;
   logic pat_valid;
   logic grp_valid;
   logic pre_valid;
   logic [NUM_W-1:0] pat_dec;
   logic [NUM_W-1:0] grp_dec;
   logic [NUM_W-1:0] pre_dec;
   logic pat_lock;
   logic grp_lock;
   logic pre_lock;
   logic zone_is_local;
   logic wr_fire;
   logic wr_pat;
   logic wr_grp;
   logic wr_pre;
   logic wr_loc;
   logic wr_hi_zero;
   logic [NUM_W-1:0] wnum;

   rst_sync u_rst_sync
   (
      .clk(clk),
      .rstn(rstn),
      .rstn_sync(rst_n_sync)
   );

   // ***********************************************************
   // Contact codes and decoding
   // ***********************************************************
   // Unassigned bits forced open, closed contact is one
   assign pat_code = {pattern_sel_bit2, pattern_sel_bit1, pattern_sel_bit0}
                     & assign_ff[ASSIGN_PAT_POS +: NUM_W];
   assign grp_code = {tune_group_bit2, tune_group_bit1, tune_group_bit0}
                     & assign_ff[ASSIGN_GRP_POS +: NUM_W];
   assign pre_code = {preset_out_bit2, preset_out_bit1, preset_out_bit0}
                     & assign_ff[ASSIGN_PRE_POS +: NUM_W];

   contact_decode #(.MAX_NUM(PATTERN_MAX)) u_pat_dec
   (
      .code(pat_code),
      .method(method_e'(method_ff[METHOD_PAT_POS])),
      .num_valid(pat_valid),
      .num(pat_dec),
      .ext_lock(pat_lock)
   );

   contact_decode #(.MAX_NUM(GROUP_MAX)) u_grp_dec
   (
      .code(grp_code),
      .method(method_e'(method_ff[METHOD_GRP_POS])),
      .num_valid(grp_valid),
      .num(grp_dec),
      .ext_lock(grp_lock)
   );

   contact_decode #(.MAX_NUM(PRESET_MAX)) u_pre_dec
   (
      .code(pre_code),
      .method(method_e'(method_ff[METHOD_PRE_POS])),
      .num_valid(pre_valid),
      .num(pre_dec),
      .ext_lock(pre_lock)
   );

   // ***********************************************************
   // Bus strobes
   // ***********************************************************
   // Write lands on the edge that sees waitrequest low
   assign wr_fire = avs_write && !waitreq_ff && avs_byteenable[0];
   assign wr_pat = wr_fire && (avs_address == OFS_PATTERN);
   assign wr_grp = wr_fire && (avs_address == OFS_GROUP);
   assign wr_pre = wr_fire && (avs_address == OFS_PRESET);
   assign wr_loc = wr_fire && (avs_address == OFS_LOCAL);
   assign wr_hi_zero = (avs_writedata[DATA_W-1:NUM_W] == '0);
   assign wnum = avs_writedata[NUM_W-1:0];
   assign zone_is_local = (zone_source_setting_ff == ZONE_LOCAL);

   // Contact beats a same-cycle keypad request; bad codes hold
   function automatic logic [NUM_W-1:0] pick(
      input logic [NUM_W-1:0] cur,
      input logic dv,
      input logic [NUM_W-1:0] dn,
      input logic wr,
      input logic [NUM_W-1:0] wn,
      input logic lock,
      input logic [NUM_W:0] maxv
   );
      logic in_range;
      in_range = (wn != '0) && ({1'b0, wn} <= maxv);
      if (dv)
         pick = dn;
      else if (wr && !lock && in_range)
         pick = wn;
      else
         pick = cur;
   endfunction

   // ***********************************************************
   // Next numbers
   // ***********************************************************
   always_comb
   begin
      nxt_pattern_num = pick(pattern_num_ff, pat_valid, pat_dec, wr_pat && wr_hi_zero, wnum,
                             pat_lock, (NUM_W+1)'(PATTERN_MAX));
      nxt_group_num = pick(group_num_ff, grp_valid && !zone_is_local, grp_dec, wr_grp && wr_hi_zero,
                           wnum, grp_lock, (NUM_W+1)'(GROUP_MAX));
      nxt_local_group = pick(local_tune_group_num_ff, grp_valid && zone_is_local, grp_dec,
                             wr_loc && wr_hi_zero, wnum, grp_lock, (NUM_W+1)'(GROUP_MAX));
      nxt_preset_num = pick(preset_num_ff, pre_valid, pre_dec, wr_pre && wr_hi_zero, wnum,
                            pre_lock, (NUM_W+1)'(PRESET_MAX));
   end

   // ***********************************************************
   // Configuration registers
   // ***********************************************************
   always_ff @(posedge clk or negedge rst_n_sync)
   begin
      if (!rst_n_sync)
      begin
         method_ff <= METHOD_RST;
         assign_ff <= ASSIGN_RST;
         zone_source_setting_ff <= ZONE_RST;
      end
      else if (wr_fire)
      begin
         if (avs_address == OFS_METHOD)
            method_ff <= avs_writedata[2:0];
         if (avs_address == OFS_ASSIGN)
            assign_ff <= avs_writedata[8:0];
         if (avs_address == OFS_ZONE)
            zone_source_setting_ff <= avs_writedata[2:0];
      end
   end

   // ***********************************************************
   // Selection numbers
   // ***********************************************************
   always_ff @(posedge clk or negedge rst_n_sync)
   begin
      if (!rst_n_sync)
      begin
         pattern_num_ff <= NUM_RST;
         group_num_ff <= NUM_RST;
         local_tune_group_num_ff <= NUM_RST;
         preset_num_ff <= NUM_RST;
         active_group_ff <= NUM_RST;
      end
      else
      begin
         pattern_num_ff <= nxt_pattern_num;
         group_num_ff <= nxt_group_num;
         local_tune_group_num_ff <= nxt_local_group;
         preset_num_ff <= nxt_preset_num;
         // Local group wins only when the zone source setting is 5 (ZONE_LOCAL)
         active_group_ff <= zone_is_local ? nxt_local_group : nxt_group_num;
      end
   end

   // ***********************************************************
   // Avalon slave
   // ***********************************************************
   always_comb
   begin
      nxt_readdata = '0;
      case (avs_address)
         OFS_METHOD: nxt_readdata = DATA_W'(method_ff);
         OFS_ASSIGN: nxt_readdata = DATA_W'(assign_ff);
         OFS_ZONE: nxt_readdata = DATA_W'(zone_source_setting_ff);
         OFS_PATTERN: nxt_readdata = DATA_W'(pattern_num_ff);
         OFS_GROUP: nxt_readdata = DATA_W'(group_num_ff);
         OFS_PRESET: nxt_readdata = DATA_W'(preset_num_ff);
         OFS_LOCAL: nxt_readdata = DATA_W'(local_tune_group_num_ff);
         OFS_STATUS:
         begin
            nxt_readdata[ASSIGN_PAT_POS +: NUM_W] = pat_code;
            nxt_readdata[ASSIGN_GRP_POS +: NUM_W] = grp_code;
            nxt_readdata[ASSIGN_PRE_POS +: NUM_W] = pre_code;
            nxt_readdata[STAT_PAT_LOCK_POS] = pat_lock;
            nxt_readdata[STAT_GRP_LOCK_POS] = grp_lock;
            nxt_readdata[STAT_PRE_LOCK_POS] = pre_lock;
            nxt_readdata[STAT_ACT_GRP_POS +: NUM_W] = active_group_ff;
         end
         default: nxt_readdata = '0;
      endcase
   end

   // Fixed one wait state keeps the read path registered
   always_ff @(posedge clk or negedge rst_n_sync)
   begin
      if (!rst_n_sync)
      begin
         waitreq_ff <= 1'b1;
         readdata_ff <= '0;
      end
      else
      begin
         waitreq_ff <= !((avs_read || avs_write) && waitreq_ff);
         if (avs_read && waitreq_ff)
            readdata_ff <= nxt_readdata;
      end
   end

   assign avs_readdata = readdata_ff;
   assign avs_waitrequest = waitreq_ff;
   assign pattern_num = pattern_num_ff;
   assign tuning_group = active_group_ff;
   assign preset_num = preset_num_ff;

   // ***********************************************************
   // Assertions
   // ***********************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n_sync);

   a_pattern_binary_follow: assert property (
      !method_ff[METHOD_PAT_POS] && pat_code != 3'h0 && pat_code <= 3'h4
      |=> pattern_num == $past(pat_code))
      else $error("pattern number not equal to binary code");

   a_pattern_keypad_accept: assert property (
      !method_ff[METHOD_PAT_POS] && pat_code == 3'h0 && wr_pat && wr_hi_zero
      && wnum != 3'h0 && wnum <= 3'h4
      |=> pattern_num == $past(wnum))
      else $error("permitted pattern request not taken");

   a_pattern_keypad_reject: assert property (
      !method_ff[METHOD_PAT_POS] && pat_code > 3'h4 && wr_pat
      |=> $stable(pattern_num))
      else $error("pattern request taken while contacts set");

   a_pattern_zero_hold: assert property (
      !method_ff[METHOD_PAT_POS] && pat_code == 3'h0 && !wr_pat
      |=> $stable(pattern_num))
      else $error("pattern number moved with contacts off");

   a_group_plus_one: assert property (
      method_ff[METHOD_GRP_POS] && grp_code <= 3'h3 && !zone_is_local
      |=> tuning_group == $past(grp_code) + 3'h1)
      else $error("group not code plus one");

   a_method2_lockout: assert property (
      method_ff[METHOD_PRE_POS] && !pre_valid && wr_pre
      |=> $stable(preset_num))
      else $error("preset request taken under method 2");

   a_preset_binary_follow: assert property (
      !method_ff[METHOD_PRE_POS] && pre_code != 3'h0 && pre_code <= 3'h5
      |=> preset_num == $past(pre_code))
      else $error("preset not equal to binary code");

   a_preset_plus_one: assert property (
      method_ff[METHOD_PRE_POS] && pre_code <= 3'h4
      |=> preset_num == $past(pre_code) + 3'h1)
      else $error("preset not code plus one");

   a_local_group_use: assert property (
      zone_is_local && grp_valid ##1 zone_is_local
      |-> tuning_group == $past(grp_dec) && local_tune_group_num_ff == $past(grp_dec))
      else $error("local group not used in zone 5");

   a_group_keypad_reject: assert property (
      !method_ff[METHOD_GRP_POS] && grp_code > 3'h4 && wr_grp && !zone_is_local
      |=> $stable(group_num_ff))
      else $error("group request taken while contacts set");

   a_bus_one_wait: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not after one wait state");

   c_pattern_by_keypad: cover property (wr_pat && !pat_lock ##1 pattern_num == 3'h3);
   c_preset_five_method2: cover property (method_ff[METHOD_PRE_POS] && pre_code == 3'h4 ##1 preset_num == 3'h5);
   c_local_group_zone: cover property (zone_is_local && grp_valid);
   c_bus_read: cover property (avs_read && !avs_waitrequest);
endmodule // contact_number_selector

// ---- sim/contact_field_model.sv ----
`timescale 1ns/1ps
module contact_field_model
(
   input wire logic clk,
   input wire logic [8:0] closed_req,
   output logic [8:0] contact_bits
);
   // ***************
   // Field contacts
   // ***************
   // Closed reads as one; contacts move one clock after the request, never mid-cycle
   always_ff @(posedge clk)
   begin
      contact_bits <= closed_req;
   end
endmodule // contact_field_model

// ---- sim/tb_contact_number_selector.sv ----
`timescale 1ns/1ps
module tb_contact_number_selector;
   import contact_sel_pkg::*;
   localparam int WATCH_CYCLES = 30000;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [8:0] closed_req = 9'h000;
   logic [8:0] contact_bits;
   logic [ADDR_W-1:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [DATA_W-1:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [DATA_W-1:0] avs_readdata;
   logic avs_waitrequest;
   logic [NUM_W-1:0] pattern_num;
   logic [NUM_W-1:0] tuning_group;
   logic [NUM_W-1:0] preset_num;
   int fail_count = 0;
   int comparisons = 0;
   integer seed;
   logic [2:0] e_pat = 3'h1;
   logic [2:0] e_grp = 3'h1;
   logic [2:0] e_loc = 3'h1;
   logic [2:0] e_pre = 3'h1;
   logic [2:0] e_meth = 3'h0;
   logic [2:0] e_zone = 3'h0;
   logic [8:0] e_mask = 9'h1ff;
   logic [8:0] e_cont = 9'h000;
   logic [31:0] q;
   int r;

   always #12.5 clk = ~clk;

   contact_field_model contact_field_model_inst (.clk(clk), .closed_req(closed_req), .contact_bits(contact_bits));

   contact_number_selector contact_number_selector_inst
   (
      .clk(clk), .rstn(rstn),
      .pattern_sel_bit0(contact_bits[0]), .pattern_sel_bit1(contact_bits[1]), .pattern_sel_bit2(contact_bits[2]),
      .tune_group_bit0(contact_bits[3]), .tune_group_bit1(contact_bits[4]), .tune_group_bit2(contact_bits[5]),
      .preset_out_bit0(contact_bits[6]), .preset_out_bit1(contact_bits[7]), .preset_out_bit2(contact_bits[8]),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .pattern_num(pattern_num), .tuning_group(tuning_group), .preset_num(preset_num)
   );

   // ***********************
   // Reference model
   // ***********************
   function automatic logic [2:0] dec(input logic [2:0] c, input logic m, input int mx, input logic [2:0] cur);
      logic [3:0] n;
      n = m ? ({1'b0, c} + 4'h1) : {1'b0, c};
      if ((!m && c == 3'h0) || int'(n) > mx)
         return cur;
      return n[2:0];
   endfunction

   function automatic logic [2:0] exp_tg();
      return (e_zone == ZONE_LOCAL) ? e_loc : e_grp;
   endfunction

   task automatic apply_contacts();
      logic [8:0] k;
      k = e_cont & e_mask;
      e_pat = dec(k[2:0], e_meth[0], PATTERN_MAX, e_pat);
      if (e_zone == ZONE_LOCAL)
         e_loc = dec(k[5:3], e_meth[1], GROUP_MAX, e_loc);
      else
         e_grp = dec(k[5:3], e_meth[1], GROUP_MAX, e_grp);
      e_pre = dec(k[8:6], e_meth[2], PRESET_MAX, e_pre);
   endtask

   // ***********************
   // Bus and compare tasks
   // ***********************
   task automatic check_num(input logic [2:0] got, input logic [2:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t number got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t read got %h expected %h", $time, got, exp);
      end
   endtask

   // Request held until waitrequest low is seen; readdata stands through that edge
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] rd);
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      avs_byteenable <= be;
      // Read before the slave's update at this edge; only the watchdog ends a hang
      do
         @(posedge clk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] v;
      bus(1'b0, a, 32'h0, 4'hf, v);
      check_word(v, exp);
   endtask

   task automatic cfg(input logic [4:0] a, input logic [8:0] v);
      bus(1'b1, a, {23'h0, v}, 4'hf, q);
      if (a == OFS_METHOD)
         e_meth = v[2:0];
      else if (a == OFS_ASSIGN)
         e_mask = v;
      else
         e_zone = v[2:0];
   endtask

   task automatic set_cont(input logic [8:0] v);
      @(posedge clk);
      closed_req <= v;
      e_cont = v;
   endtask

   // Keypad or communication request: sel 0 pattern, 1 group, 2 preset, 3 local group
   task automatic num_write(input int sel, input logic [31:0] d);
      logic [8:0] k;
      logic [2:0] code;
      logic m;
      int mx;
      k = e_cont & e_mask;
      code = (sel == 0) ? k[2:0] : (sel == 2) ? k[8:6] : k[5:3];
      m = (sel == 0) ? e_meth[0] : (sel == 2) ? e_meth[2] : e_meth[1];
      mx = (sel == 2) ? PRESET_MAX : (sel == 0) ? PATTERN_MAX : GROUP_MAX;
      bus(1'b1, OFS_PATTERN + 5'(sel * 4), d, 4'hf, q);
      if (d[31:3] == 29'h0 && d[2:0] != 3'h0 && int'(d[2:0]) <= mx && !m && code == 3'h0)
      begin
         if (sel == 0) e_pat = d[2:0];
         else if (sel == 1) e_grp = d[2:0];
         else if (sel == 2) e_pre = d[2:0];
         else e_loc = d[2:0];
      end
   endtask

   task automatic check_all();
      logic [8:0] k;
      repeat (4) @(posedge clk);
      @(negedge clk);
      apply_contacts();
      k = e_cont & e_mask;
      check_num(pattern_num, e_pat);
      check_num(tuning_group, exp_tg());
      check_num(preset_num, e_pre);
      rd_chk(OFS_STATUS, {17'h0, exp_tg(), e_meth[2] | (k[8:6] != 3'h0), e_meth[1] | (k[5:3] != 3'h0),
                          e_meth[0] | (k[2:0] != 3'h0), k});
      rd_chk(OFS_GROUP, {29'h0, e_grp});
      rd_chk(OFS_LOCAL, {29'h0, e_loc});
   endtask

   task automatic final_report();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ***********************
   // Sequence
   // ***********************
   initial
   begin
      repeat (WATCH_CYCLES) @(posedge clk);
      fail_count++;
      $display("[ERR] %0t watchdog expired", $time);
      final_report();
   end

   initial
   begin
      seed = 32'hc3699e93;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      rd_chk(OFS_METHOD, 32'h0);
      rd_chk(OFS_ASSIGN, {23'h0, ASSIGN_RST});
      rd_chk(OFS_ZONE, 32'h0);
      rd_chk(5'h02, 32'h0);
      check_all();
      bus(1'b1, OFS_PATTERN, 32'h3, 4'h0, q);
      check_all();
      num_write(0, 32'h3);
      num_write(2, 32'h6);
      num_write(1, 32'h0);
      check_all();
      for (int m = 0; m < 2; m++)
      begin
         cfg(OFS_METHOD, {6'h0, {3{m[0]}}});
         for (int c = 0; c < 8; c++)
         begin
            set_cont({3{c[2:0]}});
            check_all();
            num_write(c % 4, 32'h2 + c[0]);
            check_all();
         end
      end
      cfg(OFS_METHOD, 9'h000);
      set_cont(9'h1ff);
      cfg(OFS_ASSIGN, 9'h000);
      check_all();
      num_write(2, 32'h5);
      cfg(OFS_ZONE, 9'h005);
      set_cont(9'h018);
      check_all();
      cfg(OFS_ASSIGN, 9'h1ff);
      check_all();
      repeat (300)
      begin
         r = $unsigned($random(seed)) % 6;
         if (r == 0)
            set_cont(9'($random(seed)));
         else if (r == 1)
            set_cont(9'h000);
         else if (r == 2)
            num_write($unsigned($random(seed)) % 4, ($random(seed) % 8 == 0) ? $random(seed)
                      : 32'($unsigned($random(seed)) % 7));
         else if (r == 3)
            cfg(OFS_METHOD, 9'($unsigned($random(seed)) % 8));
         else if (r == 4)
            cfg(OFS_ASSIGN, 9'($random(seed)));
         else
            cfg(OFS_ZONE, $random(seed) % 2 == 0 ? 9'h005 : 9'($unsigned($random(seed)) % 8));
         check_all();
      end
      final_report();
   end
endmodule // tb_contact_number_selector
